/* File: hdl/mwt_compare.sv */
// Unsigned count-versus-compare stage of the wall timer
`timescale 1ns/10ps
module mwt_compare (
    input  wire logic      clk,
    input  wire logic      srst,
    mwt_core_if.cmp        cmp_if
);

    logic pending_q;
    logic pending_d;

    // Re-evaluated every cycle: stays high as a level while the
    // count is at or past the compare, drops once compare is ahead
    always_comb begin
        pending_d = (cmp_if.count >= cmp_if.compare);
    end

    // One register stage, so a write shows here one edge later
    always_ff @(posedge clk) begin
        if (srst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
        end
    end

    assign cmp_if.pending = pending_q;

endmodule

/* File: hdl/mwt_consts.svh */
// Offsets, reset values and timing counts of the machine wall timer
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef MWT_CONSTS_SVH
`define MWT_CONSTS_SVH

//----------------------------------------------------------------------
// Register map (byte addresses)
//----------------------------------------------------------------------
`define MWT_ADDR_W          5
`define MWT_OFS_COUNT       5'h00
`define MWT_OFS_COMPARE     5'h08
`define MWT_OFS_PERIOD      5'h10
`define MWT_BE_LO           8'h0f
`define MWT_BE_HI           8'hf0
`define MWT_BE_ALL          8'hff
`define MWT_LANE_LO         3'h0
`define MWT_LANE_HI         3'h4

//----------------------------------------------------------------------
// Reset values
//----------------------------------------------------------------------
`define MWT_COUNT_RST       64'h0000_0000_0000_0000
`define MWT_COMPARE_RST     64'hffff_ffff_ffff_ffff
`define MWT_RDATA_RST       64'h0000_0000_0000_0000

//----------------------------------------------------------------------
// Timing
//----------------------------------------------------------------------
`define MWT_CLK_PERIOD_NS   20
`define MWT_TICK_PERIOD_NS  1000
`define MWT_TICK_DIV        (`MWT_TICK_PERIOD_NS / `MWT_CLK_PERIOD_NS)

`endif

/* File: hdl/mwt_core_if.sv */
// Tick, count, compare and pending between the timer modules
`timescale 1ns/10ps
interface mwt_core_if;

    logic        tick;
    logic [63:0] count;
    logic [63:0] compare;
    logic        pending;

    modport tick_src (
        output tick
    );

    modport cmp (
        input  count,
        input  compare,
        output pending
    );

    modport core (
        input  tick,
        input  pending,
        output count,
        output compare
    );

endinterface

/* File: hdl/mwt_pkg.sv */
// Types shared by the machine wall timer modules
package mwt_pkg;

    typedef enum logic [0:0] {
        MWT_ST_IDLE = 1'b0,
        MWT_ST_RESP = 1'b1
    } mwt_bus_state_e;

    typedef enum logic [1:0] {
        MWT_REG_COUNT   = 2'b00,
        MWT_REG_COMPARE = 2'b01,
        MWT_REG_PERIOD  = 2'b10,
        MWT_REG_NONE    = 2'b11
    } mwt_reg_e;

endpackage

/* File: hdl/mwt_tick_gen.sv */
// Fixed-rate tick generator for the wall timer
`timescale 1ns/10ps
`include "mwt_consts.svh"
module mwt_tick_gen #(
    parameter int unsigned TICK_DIV = `MWT_TICK_DIV
) (
    input  wire logic      clk,
    input  wire logic      srst,
    mwt_core_if.tick_src   tick_if
);

    localparam int unsigned DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DW-1:0] LAST = DW'(TICK_DIV - 1);

    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic          tick_q;
    logic          tick_d;

    // Divides the fixed reference, never a scaled core clock
    always_comb begin
        div_d  = div_q + DW'(1);
        tick_d = 1'b0;
        if (div_q == LAST) begin
            div_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tick_if.tick = tick_q;

endmodule

/* File: hdl/mwt_top.sv */
// Machine wall timer: shared 64-bit counter, compare and bus slave
`timescale 1ns/10ps
`include "mwt_consts.svh"
module mwt_top #(
    parameter int unsigned NUM_HARTS   = 1,
    parameter bit          WIDE_ACCESS = 1'b1,
    parameter int unsigned TICK_DIV    = `MWT_TICK_DIV
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   bus_req,
    input  wire logic                   bus_we,
    input  wire logic [`MWT_ADDR_W-1:0] bus_addr,
    input  wire logic [7:0]             bus_be,
    input  wire logic [63:0]            bus_wdata,
    output logic                        bus_ready,
    output logic                        bus_ack,
    output logic                        bus_err,
    output logic [63:0]                 bus_rdata,
    output logic [63:0]                 wall_time,
    output logic [NUM_HARTS-1:0]        machine_timer_pending
);

    //------------------------------------------------------------------
    // Local constants
    //------------------------------------------------------------------
    localparam logic [63:0] PERIOD_NS =
        64'(TICK_DIV * `MWT_CLK_PERIOD_NS);

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    mwt_pkg::mwt_bus_state_e state_q;
    mwt_pkg::mwt_bus_state_e state_d;
    mwt_pkg::mwt_reg_e       sel;

    logic [63:0] count_q;
    logic [63:0] count_d;
    logic [63:0] count_inc;
    logic [63:0] compare_q;
    logic [63:0] compare_d;
    logic [63:0] rdata_q;
    logic [63:0] rdata_d;
    logic [63:0] wmask;
    logic        ack_q;
    logic        ack_d;
    logic        err_q;
    logic        err_d;
    logic        take;
    logic        legal;
    logic        do_write;
    logic        do_read;

    mwt_core_if core_if ();

    //------------------------------------------------------------------
    // Helper functions
    //------------------------------------------------------------------

    // Register selected by the 8-byte slot of the address
    function automatic mwt_pkg::mwt_reg_e decode_reg(
        input logic [`MWT_ADDR_W-1:0] addr
    );
        logic [`MWT_ADDR_W-1:0] base;
        base = {addr[`MWT_ADDR_W-1:3], 3'h0};
        if (base == `MWT_OFS_COUNT) begin
            decode_reg = mwt_pkg::MWT_REG_COUNT;
        end else if (base == `MWT_OFS_COMPARE) begin
            decode_reg = mwt_pkg::MWT_REG_COMPARE;
        end else if (base == `MWT_OFS_PERIOD) begin
            decode_reg = mwt_pkg::MWT_REG_PERIOD;
        end else begin
            decode_reg = mwt_pkg::MWT_REG_NONE;
        end
    endfunction

    // Low word at base, high word at base + 4, double word at base
    function automatic logic lane_ok(
        input logic [2:0] lane,
        input logic [7:0] be,
        input logic       wide_ok
    );
        lane_ok = 1'b0;
        if (be == `MWT_BE_LO) begin
            lane_ok = (lane == `MWT_LANE_LO);
        end else if (be == `MWT_BE_HI) begin
            lane_ok = (lane == `MWT_LANE_HI);
        end else if (be == `MWT_BE_ALL) begin
            lane_ok = wide_ok && (lane == `MWT_LANE_LO);
        end
    endfunction

    // Expands byte enables to a bit mask
    function automatic logic [63:0] be_mask(input logic [7:0] be);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        be_mask = m;
    endfunction

    // Replaces only the enabled bytes of a register value
    function automatic logic [63:0] merge(
        input logic [63:0] old_v,
        input logic [63:0] new_v,
        input logic [63:0] mask
    );
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Returns only the enabled bytes; the rest read as zero
    function automatic logic [63:0] lanes_of(
        input logic [63:0] v,
        input logic [63:0] mask
    );
        lanes_of = v & mask;
    endfunction

    //------------------------------------------------------------------
    // Request decode
    //------------------------------------------------------------------
    always_comb begin
        sel      = decode_reg(bus_addr);
        take     = bus_req && (state_q == mwt_pkg::MWT_ST_IDLE);
        legal    = lane_ok(bus_addr[2:0], bus_be, WIDE_ACCESS)
                   && (sel != mwt_pkg::MWT_REG_NONE)
                   && !(bus_we && (sel == mwt_pkg::MWT_REG_PERIOD));
        wmask    = be_mask(bus_be);
        do_write = take && legal && bus_we;
        do_read  = take && legal && !bus_we;
    end

    //------------------------------------------------------------------
    // Bus handshake
    //------------------------------------------------------------------

    // One request in flight; the answer cycle blocks the next one
    always_comb begin
        state_d = state_q;
        ack_d   = 1'b0;
        err_d   = 1'b0;
        case (state_q)
            mwt_pkg::MWT_ST_IDLE: begin
                if (take) begin
                    state_d = mwt_pkg::MWT_ST_RESP;
                    ack_d   = 1'b1;
                    err_d   = !legal;
                end
            end
            mwt_pkg::MWT_ST_RESP: begin
                state_d = mwt_pkg::MWT_ST_IDLE;
            end
            default: begin
                state_d = mwt_pkg::MWT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= mwt_pkg::MWT_ST_IDLE;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
        end
    end

    //------------------------------------------------------------------
    // Wall-time counter
    //------------------------------------------------------------------

    // A write lands over the ticked value, so a tick in the same cycle
    // is kept in the bytes the write leaves alone
    always_comb begin
        // Plain modular add: rolls to zero, never saturates
        count_inc = core_if.tick ? (count_q + 64'h1) : count_q;
        count_d   = count_inc;
        if (do_write && (sel == mwt_pkg::MWT_REG_COUNT)) begin
            count_d = merge(count_inc, bus_wdata, wmask);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= `MWT_COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    //------------------------------------------------------------------
    // Compare register
    //------------------------------------------------------------------

    // The only comparand; lower levels share it through software
    always_comb begin
        compare_d = compare_q;
        if (do_write && (sel == mwt_pkg::MWT_REG_COMPARE)) begin
            // A half-word store keeps the other half; the low-ones,
            // high, low order of the master then avoids a false match
            compare_d = merge(compare_q, bus_wdata, wmask);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            compare_q <= `MWT_COMPARE_RST;
        end else begin
            compare_q <= compare_d;
        end
    end

    //------------------------------------------------------------------
    // Read data
    //------------------------------------------------------------------

    // Whole 64-bit value taken in one edge: no torn double word
    always_comb begin
        rdata_d = `MWT_RDATA_RST;
        if (do_read) begin
            case (sel)
                mwt_pkg::MWT_REG_COUNT: begin
                    rdata_d = lanes_of(count_q, wmask);
                end
                mwt_pkg::MWT_REG_COMPARE: begin
                    rdata_d = lanes_of(compare_q, wmask);
                end
                mwt_pkg::MWT_REG_PERIOD: begin
                    rdata_d = lanes_of(PERIOD_NS, wmask);
                end
                default: begin
                    rdata_d = `MWT_RDATA_RST;
                end
            endcase
        end else if (state_q == mwt_pkg::MWT_ST_RESP) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= `MWT_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    //------------------------------------------------------------------
    // Tick source and comparator
    //------------------------------------------------------------------
    mwt_tick_gen #(
        .TICK_DIV (TICK_DIV)
    ) u_tick (
        .clk      (clk),
        .srst     (srst),
        .tick_if  (core_if)
    );

    mwt_compare u_cmp (
        .clk      (clk),
        .srst     (srst),
        .cmp_if   (core_if)
    );

    // Timebase and bus share clk, so the crossing is a plain register
    // hand-off; a separate timebase would need a gray or handshake path
    assign core_if.count   = count_q;
    assign core_if.compare = compare_q;

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign bus_ready = (state_q == mwt_pkg::MWT_ST_IDLE);
    assign bus_ack   = ack_q;
    assign bus_err   = err_q;
    assign bus_rdata = rdata_q;

    // Same counter and same flag fan out to every hart; each hart
    // gates the flag with its own enable
    assign wall_time             = count_q;
    assign machine_timer_pending =
        {NUM_HARTS{core_if.pending}};

endmodule

/* File: testbench/mwt_hart_model.sv */
// Hart-side bus master model for the wall timer registers
`timescale 1ns/10ps
module mwt_hart_model (
    input  wire logic        clk,
    input  wire logic        bus_ready,
    input  wire logic        bus_ack,
    input  wire logic        bus_err,
    input  wire logic [63:0] bus_rdata,
    input  wire logic        pending,
    input  wire logic        machine_timer_irq_enable,
    output logic             bus_req,
    output logic             bus_we,
    output logic [4:0]       bus_addr,
    output logic [7:0]       bus_be,
    output logic [63:0]      bus_wdata,
    output logic             irq_take
);
    // Global enable is assumed on; only the local enable gates
    assign irq_take = pending && machine_timer_irq_enable;

    initial begin
        bus_req   = 1'b0;
        bus_we    = 1'b0;
        bus_addr  = 5'h1f;
        bus_be    = 8'h00;
        bus_wdata = 64'h0;
    end

    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] b,
                       input logic [63:0] d, output logic [63:0] r,
                       output logic e);
        @(negedge clk);
        bus_req   = 1'b1;
        bus_we    = w;
        bus_addr  = a;
        bus_be    = b;
        bus_wdata = d;
        while (!bus_ready) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        r = bus_rdata;
        e = bus_ack ? bus_err : 1'bx;
        // Released lines carry junk, not the last value
        bus_req   = 1'b0;
        bus_we    = ~w;
        bus_addr  = ~a;
        bus_be    = ~b;
        bus_wdata = ~d;
    endtask

    task automatic set_cmp32(input logic [63:0] v);
        logic [63:0] r;
        logic        e;
        acc(1'b1, 5'h08, 8'h0f, 64'hffff_ffff, r, e);
        acc(1'b1, 5'h0c, 8'hf0, {v[63:32], 32'h0}, r, e);
        acc(1'b1, 5'h08, 8'h0f, {32'h0, v[31:0]}, r, e);
    endtask
endmodule

/* File: testbench/mwt_top_sva.sv */
// Port-level checker for the machine wall timer
`timescale 1ns/10ps
`include "mwt_consts.svh"
module mwt_top_sva #(
    parameter int unsigned NUM_HARTS = 1,
    parameter int unsigned TICK_DIV  = `MWT_TICK_DIV
) (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic                   bus_req,
    input wire logic                   bus_we,
    input wire logic [`MWT_ADDR_W-1:0] bus_addr,
    input wire logic [7:0]             bus_be,
    input wire logic                   bus_ready,
    input wire logic                   bus_ack,
    input wire logic                   bus_err,
    input wire logic [63:0]            bus_rdata,
    input wire logic [63:0]            wall_time,
    input wire logic [NUM_HARTS-1:0]   machine_timer_pending
);
    logic        take;
    logic        chg;
    logic        quiet;
    logic [2:0]  wr_q;
    logic [31:0] gap_q;
    logic        clean_q;
    logic [63:0] last_q;

    assign take  = bus_req && bus_ready;
    assign chg   = wall_time != last_q;
    assign quiet = wr_q == 3'h0;

    // Writes can change the count between ticks, so gaps are judged only when clean
    always_ff @(posedge clk) begin
        last_q <= wall_time;
        if (srst) begin
            wr_q    <= 3'h0;
            gap_q   <= 32'h0;
            clean_q <= 1'b0;
        end else begin
            wr_q    <= {wr_q[1:0], take && bus_we};
            gap_q   <= chg ? 32'h0 : gap_q + 32'h1;
            clean_q <= (!quiet || (take && bus_we)) ? 1'b0 : (chg || clean_q);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_ack_next: assert property (take |=> bus_ack)
        else $error("no ack after a taken request");
    a_ack_cause: assert property (bus_ack |-> $past(take))
        else $error("ack without a taken request");
    a_ack_busy: assert property (
        bus_ack |-> !bus_ready ##1 (bus_ready && !bus_ack))
        else $error("ack not a single busy cycle");
    a_err_clean: assert property (
        bus_err |-> bus_ack && bus_rdata == 64'h0)
        else $error("refusal without ack or with data");
    a_lane_zero: assert property (
        bus_ack && !bus_err && $past(!bus_we && bus_be == 8'h0f)
        |-> bus_rdata[63:32] == 32'h0)
        else $error("disabled read lanes not zero");
    a_bad_addr: assert property (
        take && bus_addr[4:3] == 2'h3 |=> bus_ack && bus_err)
        else $error("unmapped access not refused");
    a_reset_vals: assert property (
        $fell(srst) |-> bus_ready && !bus_ack && wall_time == 64'h0
        && machine_timer_pending == '0)
        else $error("outputs not at reset values");
    a_count_step: assert property (
        chg && quiet |-> wall_time == last_q + 64'h1)
        else $error("count did not step by one");
    a_tick_exact: assert property (
        chg && quiet && clean_q |-> gap_q == TICK_DIV - 1)
        else $error("tick spacing wrong");
    a_tick_bound: assert property (gap_q <= TICK_DIV + 2)
        else $error("count stalled");
    a_harts_same: assert property (
        machine_timer_pending == '0 || machine_timer_pending == '1)
        else $error("harts see different pending");
    // A wrap to zero may drop the flag, so only a count that does not fall counts
    a_pend_hold: assert property (
        machine_timer_pending[0] && quiet && !take
        && wall_time >= last_q |=> machine_timer_pending[0])
        else $error("pending dropped without a write");
endmodule

bind mwt_top mwt_top_sva #(.NUM_HARTS(NUM_HARTS), .TICK_DIV(TICK_DIV)) u_sva (
    .clk, .srst, .bus_req, .bus_we, .bus_addr, .bus_be, .bus_ready,
    .bus_ack, .bus_err, .bus_rdata, .wall_time, .machine_timer_pending
);

/* File: testbench/testbench.sv */
// Self-checking bench for the machine wall timer
`timescale 1ns/10ps
module testbench;
    localparam int unsigned TD = 4;
    localparam int unsigned NH = 2;
    logic          clk;
    logic          srst;
    logic          req, we, ready, ack, err, irq_on;
    logic [4:0]    addr;
    logic [7:0]    be;
    logic [63:0]   wdata, rdata, wall, m_cnt, m_cmp, r;
    logic [NH-1:0] pend;
    int            n_mismatch, compares, cyc, div, seed, t;
    logic [4:0]    ea [5] = '{5'h18, 5'h10, 5'h04, 5'h0c, 5'h08};
    logic [7:0]    eb [5] = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hf0};

    mwt_top #(.NUM_HARTS(NH), .WIDE_ACCESS(1'b1), .TICK_DIV(TD)) dut (
        .clk(clk), .srst(srst), .bus_req(req), .bus_we(we),
        .bus_addr(addr), .bus_be(be), .bus_wdata(wdata),
        .bus_ready(ready), .bus_ack(ack), .bus_err(err),
        .bus_rdata(rdata), .wall_time(wall), .machine_timer_pending(pend)
    );
    mwt_hart_model hart (
        .clk(clk), .bus_ready(ready), .bus_ack(ack), .bus_err(err),
        .bus_rdata(rdata), .pending(pend[0]),
        .machine_timer_irq_enable(irq_on), .bus_req(req), .bus_we(we),
        .bus_addr(addr), .bus_be(be), .bus_wdata(wdata), .irq_take()
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Reference counter and hang limit
    always @(posedge clk) begin
        cyc++;
        if (srst) begin
            div   = 0;
            m_cnt = 64'h0;
            m_cmp = '1;
        end else if (div == TD - 1) begin
            div   = 0;
            m_cnt = m_cnt + 64'h1;
        end else
            div++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string n, input logic [63:0] s,
                       input logic [63:0] x);
        compares++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", n, x, s);
        end
    endtask

    // Count reads allow a skew of the tick phase from two ticks ahead to three behind
    task automatic op(input logic w, input logic [4:0] a, input logic [7:0] b,
                      input logic [63:0] d, input logic xe);
        logic [63:0] m;
        logic        e;
        for (int i = 0; i < 8; i++) m[i*8+:8] = {8{b[i]}};
        hart.acc(w, a, b, d, r, e);
        chk("err", {63'h0, e}, {63'h0, xe});
        if (xe)
            chk("refused rdata", r, 64'h0);
        else if (w && a[4:3] == 2'h0)
            m_cnt = (m_cnt & ~m) | (d & m);
        else if (w)
            m_cmp = (m_cmp & ~m) | (d & m);
        else if (a[4:3] == 2'h1)
            chk("compare", r, m_cmp & m);
        else if (a[4:3] == 2'h2)
            chk("period", r, 64'(TD * 20) & m);
        else
            chk("count", 64'((m_cnt & m) - r + 64'h2 <= 64'h5), 64'h1);
    endtask

    task automatic pchk;
        repeat (2) @(negedge clk);
        chk("pending", 64'(pend), {62'h0, {NH{m_cnt >= m_cmp}}});
        chk("wall", 64'(m_cnt - wall + 64'h2 <= 64'h5), 64'h1);
    endtask

    task automatic results;
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        seed = 8286;
        srst = 1'b1;
        irq_on = 1'b0;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        op(0, 5'h00, 8'hff, 0, 0);
        op(0, 5'h08, 8'hff, 0, 0);
        op(0, 5'h10, 8'hff, 0, 0);
        pchk();
        $display("test reset done");
        for (t = 0; t < 4; t++) begin
            irq_on = t[0];
            op(1, 5'h08, 8'hff, {$random(seed), $random(seed)}, 0);
            op(1, 5'h08, 8'h0f, {32'h0, $random(seed)}, 0);
            op(0, 5'h0c, 8'hf0, 0, 0);
            op(1, 5'h0c, 8'hf0, {$random(seed), 32'h0}, 0);
            op(0, 5'h08, 8'h0f, 0, 0);
            op(0, 5'h08, 8'hff, 0, 0);
            op(1, 5'h00, 8'hff, {$random(seed), $random(seed)}, 0);
            op(0, 5'h00, 8'hff, 0, 0);
        end
        $display("test access done");
        for (t = 0; t < 5; t++) op(t != 0, ea[t], eb[t], 64'h5a5a_a5a5_0ff0_f00f, 1);
        op(0, 5'h08, 8'hff, 0, 0);
        $display("test refusal done");
        op(1, 5'h00, 8'hff, 64'hffff_ffff_ffff_fffa, 0);
        repeat (12 * TD) @(negedge clk);
        op(0, 5'h00, 8'hff, 0, 0);
        $display("test wrap done");
        op(1, 5'h00, 8'hff, 64'h1000, 0);
        op(1, 5'h08, 8'hff, 64'h1100, 0);
        pchk();
        op(1, 5'h08, 8'hff, 64'h0ff0, 0);
        pchk();
        hart.set_cmp32(64'h1_0000_0000);
        m_cmp = 64'h1_0000_0000;
        pchk();
        op(1, 5'h08, 8'hff, 64'h1030, 0);
        pchk();
        repeat (40 * TD) @(negedge clk);
        pchk();
        $display("test pending done");
        results();
    end
endmodule
